//--- logic/hmrf_mci_chan.sv
// One monitor and command/indicate channel with its flags
`timescale 1ns/1ps
module hmrf_mci_chan (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic chan_reset_i,
    input wire logic stat_wr_i,
    input wire logic [7:0] stat_wdata_i,
    input wire logic mon_tx_wr_i,
    input wire logic [7:0] mon_tx_wdata_i,
    input wire logic mon_rx_rd_i,
    input wire logic mon_tx_taken_i,
    input wire logic remote_abort_i,
    input wire logic mon_frame_i,
    input wire logic [7:0] mon_byte_i,
    input wire logic mon_eom_i,
    input wire logic ci_valid_i,
    input wire logic [hmrf_pkg::CI_W-1:0] ci_byte_i,
    output logic [7:0] status_o,
    output logic [7:0] monitor_rx_reg_o,
    output logic [7:0] monitor_tx_reg_o,
    output logic mon_tx_valid_o,
    output logic [hmrf_pkg::CI_W-1:0] ci_receive_reg_o
);
    logic [7:0] stat_r, stat_nxt, set_v, clr_v;
    logic [7:0] mrx_r, mrx_nxt, last_r, last_nxt, mtx_r, mtx_nxt;
    logic pend_r, pend_nxt;
    logic owe_r, owe_nxt;
    logic [hmrf_pkg::CI_W-1:0] cir_r, cir_nxt;
    hmrf_pkg::hmrf_mrx_t st_r, st_nxt;

    // ***************************************************
    // Next state
    // ***************************************************
    always_comb begin
        set_v = hmrf_pkg::STATUS_RST;
        clr_v = stat_wr_i ? ~stat_wdata_i : hmrf_pkg::STATUS_RST;
        st_nxt = st_r;
        mrx_nxt = mrx_r;
        last_nxt = last_r;
        mtx_nxt = mtx_r;
        pend_nxt = pend_r;
        owe_nxt = owe_r;
        cir_nxt = cir_r;
        // Transmit side: a write is lost while remote abort stands
        if (mon_tx_wr_i && !stat_r[hmrf_pkg::CS_REM_ABORT]) begin
            mtx_nxt = mon_tx_wdata_i;
            pend_nxt = 1'b1;
        end else if (mon_tx_taken_i && pend_r) begin
            pend_nxt = 1'b0;
            set_v[hmrf_pkg::CS_TX_READY] = 1'b1;
        end
        if (remote_abort_i) begin
            pend_nxt = 1'b0;
            set_v[hmrf_pkg::CS_REM_ABORT] = 1'b1;
        end
        // Receive side: a byte must repeat in the next frame
        if (mon_rx_rd_i) begin
            owe_nxt = 1'b0;
        end
        case (st_r)
            hmrf_pkg::HMRF_MR_IDLE: begin
                if (mon_eom_i) begin
                    set_v[hmrf_pkg::CS_MSG_END] = 1'b1;
                    st_nxt = hmrf_pkg::HMRF_MR_LOCK;
                end else if (mon_frame_i) begin
                    last_nxt = mon_byte_i;
                    st_nxt = hmrf_pkg::HMRF_MR_CHECK;
                end
            end
            hmrf_pkg::HMRF_MR_CHECK: begin
                if (mon_eom_i) begin
                    set_v[hmrf_pkg::CS_MSG_END] = 1'b1;
                    st_nxt = hmrf_pkg::HMRF_MR_LOCK;
                end else if (mon_frame_i && mon_byte_i == last_r) begin
                    mrx_nxt = mon_byte_i;
                    set_v[hmrf_pkg::CS_RX_READY] = 1'b1;
                    owe_nxt = 1'b1;
                    st_nxt = hmrf_pkg::HMRF_MR_LOCK;
                end else if (mon_frame_i) begin
                    set_v[hmrf_pkg::CS_RX_ABORT] = 1'b1;
                    st_nxt = hmrf_pkg::HMRF_MR_LOCK;
                end
            end
            hmrf_pkg::HMRF_MR_LOCK: begin
                // Clearing ready alone does not free it; a read must come
                if ((mon_rx_rd_i || !owe_r)
                    && !stat_r[hmrf_pkg::CS_RX_ABORT]
                    && !stat_r[hmrf_pkg::CS_MSG_END]) begin
                    st_nxt = hmrf_pkg::HMRF_MR_IDLE;
                end
            end
            default: st_nxt = hmrf_pkg::HMRF_MR_IDLE;
        endcase
        if (ci_valid_i) begin
            cir_nxt = ci_byte_i;
            set_v[hmrf_pkg::CS_CI_CHANGE] = 1'b1;
        end
        stat_nxt = set_v | (stat_r & ~clr_v);
        if (chan_reset_i) begin
            stat_nxt = hmrf_pkg::STATUS_RST;
            st_nxt = hmrf_pkg::HMRF_MR_IDLE;
            owe_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
    end

    // ***************************************************
    // Registers
    // ***************************************************
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            stat_r <= hmrf_pkg::STATUS_RST;
            st_r <= hmrf_pkg::HMRF_MR_IDLE;
            mrx_r <= hmrf_pkg::BYTE_RST;
            last_r <= hmrf_pkg::BYTE_RST;
            mtx_r <= hmrf_pkg::BYTE_RST;
            pend_r <= 1'b0;
            owe_r <= 1'b0;
            cir_r <= hmrf_pkg::CI_RST;
        end else begin
            stat_r <= stat_nxt;
            st_r <= st_nxt;
            mrx_r <= mrx_nxt;
            last_r <= last_nxt;
            mtx_r <= mtx_nxt;
            pend_r <= pend_nxt;
            owe_r <= owe_nxt;
            cir_r <= cir_nxt;
        end
    end

    assign status_o = stat_r;
    assign monitor_rx_reg_o = mrx_r;
    assign monitor_tx_reg_o = mtx_r;
    assign mon_tx_valid_o = pend_r;
    assign ci_receive_reg_o = cir_r;
endmodule // hmrf_mci_chan

//--- logic/hmrf_pkg.sv
// Constants shared by the soft reset and interrupt flag logic
//
// Functional notes
// - Remote abort cleared before next monitor byte
// - Valid C/I byte sets change flag, readable
// - Transmit reset level holds transmitter initial
// - Transmit reset clears pool ready, keeps underrun
// - Host pulses transmit reset, awaits pool ready
// - Receive reset level holds receiver initial
// - Receive reset clears end, full, overflow flags
// - After receive reset, wait for flag
// - Per-channel reset initialises monitor and C/I
// - Channel reset clears all six channel flags
// - Writing zero clears flag, one keeps it
// - Underrun aborts, freezes until reset after clear
// - Monitor byte accepted when repeated, then locks
package hmrf_pkg;
    // ***************************************************
    // HDLC status byte layout
    // ***************************************************
    localparam int HS_MSG_END = 7;
    localparam int HS_RX_FULL = 6;
    localparam int HS_RX_OVF = 5;
    localparam int HS_TX_READY = 4;
    localparam int HS_TX_UNDER = 3;
    // ***************************************************
    // Channel status byte layout
    // ***************************************************
    localparam int CS_TX_READY = 0;
    localparam int CS_REM_ABORT = 1;
    localparam int CS_RX_READY = 2;
    localparam int CS_CI_CHANGE = 3;
    localparam int CS_RX_ABORT = 4;
    localparam int CS_MSG_END = 5;
    // ***************************************************
    // Sizes and reset values
    // ***************************************************
    localparam int CI_W = 4;
    localparam int NCHAN = 2;
    localparam logic [6:0] BLOCK_BYTES = 7'h20;
    localparam logic [6:0] FIFO_BYTES = 7'h40;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [6:0] COUNT_RST = 7'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [CI_W-1:0] CI_RST = 4'h0;
    typedef enum logic [1:0] {
        HMRF_MR_IDLE = 2'b00,
        HMRF_MR_CHECK = 2'b01,
        HMRF_MR_LOCK = 2'b10
    } hmrf_mrx_t;
endpackage

//--- logic/hmrf_top.sv
// Soft reset commands and interrupt flags of the HDLC and M/CI paths
`timescale 1ns/1ps
module hmrf_top (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic tx_reset_cmd_i,
    input wire logic rx_reset_cmd_i,
    input wire logic [1:0] monitor_ci_reset_cmd_i,
    input wire logic hdlc_stat_wr_i,
    input wire logic [7:0] hdlc_stat_wdata_i,
    input wire logic tx_fifo_wr_i,
    input wire logic tx_line_req_i,
    input wire logic tx_line_end_i,
    input wire logic rx_line_flag_i,
    input wire logic rx_line_byte_i,
    input wire logic rx_line_end_i,
    input wire logic rx_fifo_rd_i,
    input wire logic [1:0] chan_stat_wr_i,
    input wire logic [15:0] chan_stat_wdata_i,
    input wire logic [1:0] mon_tx_wr_i,
    input wire logic [15:0] mon_tx_wdata_i,
    input wire logic [1:0] mon_rx_rd_i,
    input wire logic [1:0] mon_tx_taken_i,
    input wire logic [1:0] remote_abort_i,
    input wire logic [1:0] mon_frame_i,
    input wire logic [15:0] mon_byte_i,
    input wire logic [1:0] mon_eom_i,
    input wire logic [1:0] ci_valid_i,
    input wire logic [7:0] ci_byte_i,
    output logic [7:0] hdlc_irq_status_reg_o,
    output logic tx_byte_valid_o,
    output logic tx_abort_o,
    output logic tx_frozen_o,
    output logic rx_hunt_o,
    output logic [6:0] rx_fifo_count_o,
    output logic [15:0] irq_status_reg_o,
    output logic [15:0] monitor_rx_reg_o,
    output logic [15:0] monitor_tx_reg_o,
    output logic [1:0] mon_tx_valid_o,
    output logic [7:0] ci_receive_reg_o
);
    logic [7:0] hst_r;
    logic [7:0] hst_nxt;
    logic [7:0] hset;
    logic [7:0] hclr;
    logic [6:0] txc_r;
    logic [6:0] txc_nxt;
    logic [6:0] rxc_r;
    logic [6:0] rxc_nxt;
    logic [6:0] rblk_r;
    logic [6:0] rblk_nxt;
    logic txf_r;
    logic txf_nxt;
    logic txfrm_r;
    logic txfrm_nxt;
    logic avail_r;
    logic avail_nxt;
    logic abort_r;
    logic abort_nxt;
    logic hunt_r;
    logic hunt_nxt;
    logic tbv_r;
    logic tbv_nxt;
    logic tx_take;
    logic tx_put;
    logic rx_put;
    logic rx_get;

    // ***************************************************
    // Transmit path and HDLC status flags
    // ***************************************************
    always_comb begin
        hset = hmrf_pkg::STATUS_RST;
        hclr = hdlc_stat_wr_i ? ~hdlc_stat_wdata_i
                              : hmrf_pkg::STATUS_RST;
        txf_nxt = txf_r;
        txfrm_nxt = txfrm_r;
        abort_nxt = 1'b0;
        tbv_nxt = 1'b0;
        tx_put = tx_fifo_wr_i && !txf_r && !tx_reset_cmd_i
                 && txc_r != hmrf_pkg::FIFO_BYTES;
        tx_take = tx_line_req_i && !txf_r && !tx_reset_cmd_i
                  && txc_r != hmrf_pkg::COUNT_RST;
        txc_nxt = txc_r + 7'(tx_put) - 7'(tx_take);
        if (tx_take) begin
            txfrm_nxt = 1'b1;
            tbv_nxt = 1'b1;
        end
        if (tx_line_end_i) begin
            txfrm_nxt = 1'b0;
        end
        // Running dry inside a frame aborts it and freezes
        if (tx_line_req_i && txfrm_r && !txf_r && !tx_reset_cmd_i
            && txc_r == hmrf_pkg::COUNT_RST) begin
            hset[hmrf_pkg::HS_TX_UNDER] = 1'b1;
            abort_nxt = 1'b1;
            txf_nxt = 1'b1;
            txfrm_nxt = 1'b0;
        end
        // Pool ready rises when a whole block becomes free
        avail_nxt = !txf_r && !tx_reset_cmd_i
                    && txc_r <= hmrf_pkg::FIFO_BYTES - hmrf_pkg::BLOCK_BYTES;
        if (avail_nxt && !avail_r) begin
            hset[hmrf_pkg::HS_TX_READY] = 1'b1;
        end
        if (tx_reset_cmd_i) begin
            txc_nxt = hmrf_pkg::COUNT_RST;
            txfrm_nxt = 1'b0;
            tbv_nxt = 1'b0;
            hset[hmrf_pkg::HS_TX_READY] = 1'b0;
            hclr[hmrf_pkg::HS_TX_READY] = 1'b1;
            // Leaves the freeze only once underrun was cleared
            if (!hst_r[hmrf_pkg::HS_TX_UNDER]) begin
                txf_nxt = 1'b0;
            end
        end
        // *************************************************
        // Receive path
        // *************************************************
        hunt_nxt = hunt_r;
        rx_put = rx_line_byte_i && !hunt_r && !rx_reset_cmd_i;
        rx_get = rx_fifo_rd_i && !rx_reset_cmd_i
                 && rxc_r != hmrf_pkg::COUNT_RST;
        rblk_nxt = rblk_r;
        // A full pool drops the byte unless a read makes room
        if (rx_put && rxc_r == hmrf_pkg::FIFO_BYTES && !rx_get) begin
            hset[hmrf_pkg::HS_RX_OVF] = 1'b1;
            rx_put = 1'b0;
        end
        rxc_nxt = rxc_r + 7'(rx_put) - 7'(rx_get);
        if (rx_put) begin
            rblk_nxt = rblk_r + 7'h01;
            if (rblk_r + 7'h01 == hmrf_pkg::BLOCK_BYTES) begin
                hset[hmrf_pkg::HS_RX_FULL] = 1'b1;
                rblk_nxt = hmrf_pkg::COUNT_RST;
            end
        end
        if (rx_line_end_i && !hunt_r && !rx_reset_cmd_i) begin
            hset[hmrf_pkg::HS_MSG_END] = 1'b1;
            rblk_nxt = hmrf_pkg::COUNT_RST;
        end
        // The rest of a frame cut by reset is skipped
        if (rx_line_flag_i && !rx_reset_cmd_i) begin
            hunt_nxt = 1'b0;
        end
        if (rx_reset_cmd_i) begin
            hunt_nxt = 1'b1;
            rxc_nxt = hmrf_pkg::COUNT_RST;
            rblk_nxt = hmrf_pkg::COUNT_RST;
            hset[hmrf_pkg::HS_MSG_END] = 1'b0;
            hset[hmrf_pkg::HS_RX_FULL] = 1'b0;
            hset[hmrf_pkg::HS_RX_OVF] = 1'b0;
            hclr[hmrf_pkg::HS_MSG_END] = 1'b1;
            hclr[hmrf_pkg::HS_RX_FULL] = 1'b1;
            hclr[hmrf_pkg::HS_RX_OVF] = 1'b1;
        end
        hst_nxt = hset | (hst_r & ~hclr);
    end

    // ***************************************************
    // HDLC state registers
    // ***************************************************
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            hst_r <= hmrf_pkg::STATUS_RST;
            txc_r <= hmrf_pkg::COUNT_RST;
            rxc_r <= hmrf_pkg::COUNT_RST;
            rblk_r <= hmrf_pkg::COUNT_RST;
            txf_r <= 1'b0;
            txfrm_r <= 1'b0;
            avail_r <= 1'b0;
            abort_r <= 1'b0;
            hunt_r <= 1'b1;
            tbv_r <= 1'b0;
        end else begin
            hst_r <= hst_nxt;
            txc_r <= txc_nxt;
            rxc_r <= rxc_nxt;
            rblk_r <= rblk_nxt;
            txf_r <= txf_nxt;
            txfrm_r <= txfrm_nxt;
            avail_r <= avail_nxt;
            abort_r <= abort_nxt;
            hunt_r <= hunt_nxt;
            tbv_r <= tbv_nxt;
        end
    end

    // ***************************************************
    // HDLC outputs
    // ***************************************************
    assign hdlc_irq_status_reg_o = hst_r;
    assign tx_byte_valid_o = tbv_r;
    assign tx_abort_o = abort_r;
    assign tx_frozen_o = txf_r;
    assign rx_hunt_o = hunt_r;
    assign rx_fifo_count_o = rxc_r;

    // ***************************************************
    // Monitor and C/I channels
    // ***************************************************
    // Each channel owns its flags and its reset input
    for (genvar c = 0; c < hmrf_pkg::NCHAN; c++) begin : g_chan
        hmrf_mci_chan u_chan (
            .mclk_i(mclk_i),
            .rstn_i(rstn_i),
            .chan_reset_i(monitor_ci_reset_cmd_i[c]),
            .stat_wr_i(chan_stat_wr_i[c]),
            .stat_wdata_i(chan_stat_wdata_i[c*8 +: 8]),
            .mon_tx_wr_i(mon_tx_wr_i[c]),
            .mon_tx_wdata_i(mon_tx_wdata_i[c*8 +: 8]),
            .mon_rx_rd_i(mon_rx_rd_i[c]),
            .mon_tx_taken_i(mon_tx_taken_i[c]),
            .remote_abort_i(remote_abort_i[c]),
            .mon_frame_i(mon_frame_i[c]),
            .mon_byte_i(mon_byte_i[c*8 +: 8]),
            .mon_eom_i(mon_eom_i[c]),
            .ci_valid_i(ci_valid_i[c]),
            .ci_byte_i(ci_byte_i[c*4 +: 4]),
            .status_o(irq_status_reg_o[c*8 +: 8]),
            .monitor_rx_reg_o(monitor_rx_reg_o[c*8 +: 8]),
            .monitor_tx_reg_o(monitor_tx_reg_o[c*8 +: 8]),
            .mon_tx_valid_o(mon_tx_valid_o[c]),
            .ci_receive_reg_o(ci_receive_reg_o[c*4 +: 4])
        );
    end
endmodule // hmrf_top

//--- test/hmrf_assertions.sv
// Assertion checker for the soft reset and interrupt flag logic
`timescale 1ns/1ps
module hmrf_assertions (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic tx_reset_cmd_i,
    input wire logic rx_reset_cmd_i,
    input wire logic [1:0] monitor_ci_reset_cmd_i,
    input wire logic hdlc_stat_wr_i,
    input wire logic [7:0] hdlc_stat_wdata_i,
    input wire logic tx_line_req_i,
    input wire logic [1:0] mon_tx_wr_i,
    input wire logic [1:0] ci_valid_i,
    input wire logic [7:0] ci_byte_i,
    input wire logic [7:0] hdlc_irq_status_reg_o,
    input wire logic tx_abort_o,
    input wire logic tx_frozen_o,
    input wire logic rx_hunt_o,
    input wire logic [6:0] rx_fifo_count_o,
    input wire logic [15:0] irq_status_reg_o,
    input wire logic [1:0] mon_tx_valid_o,
    input wire logic [7:0] ci_receive_reg_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    property p_txr_xpr;
        tx_reset_cmd_i |=> !hdlc_irq_status_reg_o[hmrf_pkg::HS_TX_READY];
    endproperty
    a_txr_xpr: assert property (p_txr_xpr)
        else $error("pool ready kept through tx reset");
    property p_txr_xdu;
        tx_reset_cmd_i && !hdlc_stat_wr_i
            |=> $stable(hdlc_irq_status_reg_o[hmrf_pkg::HS_TX_UNDER]);
    endproperty
    a_txr_xdu: assert property (p_txr_xdu)
        else $error("underrun flag changed by tx reset");
    property p_rxr_flags;
        rx_reset_cmd_i |=> hdlc_irq_status_reg_o[7:5] == 3'h0;
    endproperty
    a_rxr_flags: assert property (p_rxr_flags)
        else $error("rx flags survive rx reset");
    property p_rxr_hunt;
        rx_reset_cmd_i |=> rx_hunt_o && rx_fifo_count_o == 7'h00;
    endproperty
    a_rxr_hunt: assert property (p_rxr_hunt)
        else $error("receiver not initial under rx reset");
    property p_chr_flags;
        monitor_ci_reset_cmd_i[0] |=> irq_status_reg_o[5:0] == 6'h00;
    endproperty
    a_chr_flags: assert property (p_chr_flags)
        else $error("channel flags survive channel reset");
    property p_wr_zero;
        hdlc_stat_wr_i && !hdlc_stat_wdata_i[hmrf_pkg::HS_TX_UNDER]
            && !tx_line_req_i
            |=> !hdlc_irq_status_reg_o[hmrf_pkg::HS_TX_UNDER];
    endproperty
    a_wr_zero: assert property (p_wr_zero)
        else $error("zero write did not clear underrun");
    property p_ci_set;
        ci_valid_i[0] && !monitor_ci_reset_cmd_i[0] |=> irq_status_reg_o[3]
            && ci_receive_reg_o[3:0] == $past(ci_byte_i[3:0]);
    endproperty
    a_ci_set: assert property (p_ci_set)
        else $error("ci byte not flagged or stored");
    property p_rab_drop;
        mon_tx_wr_i[0] && irq_status_reg_o[1] && !mon_tx_valid_o[0]
            |=> !mon_tx_valid_o[0];
    endproperty
    a_rab_drop: assert property (p_rab_drop)
        else $error("monitor byte taken while remote abort set");
    property p_freeze;
        $rose(tx_frozen_o) |-> tx_abort_o
            && hdlc_irq_status_reg_o[hmrf_pkg::HS_TX_UNDER];
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("freeze without abort and underrun");
endmodule // hmrf_assertions

bind hmrf_top hmrf_assertions i_hmrf_assertions (.*);

//--- test/hmrf_line_model.sv
// Line-side model that sends pending monitor bytes after a delay
`timescale 1ns/1ps
module hmrf_line_model #(
    parameter int DLY = 3
) (
    input wire logic mclk_i,
    input wire logic [1:0] valid_i,
    output logic [1:0] taken_o
);
    int cnt = 0;
    logic [1:0] tk_r = 2'h0;
    assign taken_o = tk_r;
    always @(posedge mclk_i) begin
        if (tk_r != 2'h0 || valid_i == 2'h0) begin
            cnt <= 0;
            tk_r <= 2'h0;
        end else if (cnt == DLY) begin
            tk_r <= valid_i;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // hmrf_line_model

//--- test/test_hdlc_mci_soft_reset_flags.sv
// Self-checking bench for the soft reset and interrupt flag logic
`timescale 1ns/1ps
module test_hdlc_mci_soft_reset_flags;
    logic mclk_i = '0, rstn_i = '0, tx_reset_cmd_i = '0, rx_reset_cmd_i = '0;
    logic hdlc_stat_wr_i = '0, tx_fifo_wr_i = '0, tx_line_req_i = '0;
    logic tx_line_end_i = '0, rx_line_flag_i = '0, rx_line_byte_i = '0;
    logic rx_line_end_i = '0, rx_fifo_rd_i = '0;
    logic [1:0] monitor_ci_reset_cmd_i = '0, chan_stat_wr_i = '0;
    logic [1:0] mon_tx_wr_i = '0, mon_rx_rd_i = '0, remote_abort_i = '0;
    logic [1:0] mon_frame_i = '0, mon_eom_i = '0, ci_valid_i = '0;
    logic [1:0] mon_tx_taken_i, mon_tx_valid_o;
    logic [7:0] hdlc_stat_wdata_i = '0, ci_byte_i = '0;
    logic [15:0] chan_stat_wdata_i = '0, mon_tx_wdata_i = '0, mon_byte_i = '0;
    logic [7:0] hdlc_irq_status_reg_o, ci_receive_reg_o;
    logic tx_byte_valid_o, tx_abort_o, tx_frozen_o, rx_hunt_o;
    logic [6:0] rx_fifo_count_o;
    logic [15:0] irq_status_reg_o, monitor_rx_reg_o, monitor_tx_reg_o;
    int error_cnt = 0, checked = 0;

    hmrf_top i_hmrf_top (.*);
    hmrf_line_model i_hmrf_line_model (
        .mclk_i(mclk_i),
        .valid_i(mon_tx_valid_o),
        .taken_o(mon_tx_taken_i)
    );

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task wrap_up;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task hwr(input logic [7:0] d);
        hdlc_stat_wdata_i = d;
        hdlc_stat_wr_i = 1'b1;
        cyc(1);
        hdlc_stat_wr_i = 1'b0;
    endtask

    task cwr(input logic [1:0] c, input logic [15:0] d);
        chan_stat_wdata_i = d;
        chan_stat_wr_i = c;
        cyc(1);
        chan_stat_wr_i = 2'h0;
    endtask

    initial begin
        #50000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        cyc(2);
        rstn_i = 1'b1;
        cyc(2);
        chk(hdlc_irq_status_reg_o, 8'h10);
        tx_fifo_wr_i = 1'b1;
        cyc(1);
        tx_fifo_wr_i = 1'b0;
        tx_line_req_i = 1'b1;
        cyc(1);
        chk(tx_byte_valid_o, 1'b1);
        cyc(1);
        tx_line_req_i = 1'b0;
        chk({tx_abort_o, tx_frozen_o, hdlc_irq_status_reg_o}, 10'h318);
        tx_reset_cmd_i = 1'b1;
        cyc(1);
        chk(hdlc_irq_status_reg_o, 8'h08);
        tx_reset_cmd_i = 1'b0;
        cyc(3);
        chk(tx_frozen_o, 1'b1);
        hwr(8'hf7);
        chk(hdlc_irq_status_reg_o[3], 1'b0);
        tx_reset_cmd_i = 1'b1;
        cyc(1);
        tx_reset_cmd_i = 1'b0;
        cyc(2);
        chk({tx_frozen_o, hdlc_irq_status_reg_o}, 9'h010);
        hwr(8'hef);
        chk(hdlc_irq_status_reg_o, 8'h00);
        rx_line_flag_i = 1'b1;
        cyc(1);
        rx_line_flag_i = 1'b0;
        rx_line_byte_i = 1'b1;
        cyc(32);
        rx_line_byte_i = 1'b0;
        chk({hdlc_irq_status_reg_o[6], rx_fifo_count_o}, 8'ha0);
        rx_reset_cmd_i = 1'b1;
        cyc(1);
        rx_reset_cmd_i = 1'b0;
        chk({hdlc_irq_status_reg_o[7:5], rx_hunt_o, rx_fifo_count_o}, 11'h080);
        rx_line_byte_i = 1'b1;
        cyc(1);
        rx_line_byte_i = 1'b0;
        chk(rx_fifo_count_o, 7'h00);
        rx_line_flag_i = 1'b1;
        cyc(1);
        rx_line_flag_i = 1'b0;
        rx_line_byte_i = 1'b1;
        cyc(1);
        rx_line_byte_i = 1'b0;
        rx_line_end_i = 1'b1;
        cyc(1);
        rx_line_end_i = 1'b0;
        chk({hdlc_irq_status_reg_o[7], rx_fifo_count_o}, 8'h81);
        mon_byte_i = 16'h00a5;
        mon_frame_i = 2'h1;
        cyc(2);
        mon_frame_i = 2'h0;
        chk({irq_status_reg_o[2], monitor_rx_reg_o[7:0]}, 9'h1a5);
        cwr(2'h1, 16'hfffb);
        mon_rx_rd_i = 2'h1;
        cyc(1);
        mon_rx_rd_i = 2'h0;
        remote_abort_i = 2'h1;
        cyc(1);
        remote_abort_i = 2'h0;
        mon_tx_wdata_i = 16'h003c;
        mon_tx_wr_i = 2'h1;
        cyc(1);
        mon_tx_wr_i = 2'h0;
        chk({irq_status_reg_o[1], mon_tx_valid_o}, 3'h4);
        cwr(2'h1, 16'hfffd);
        cyc(1);
        cwr(2'h1, 16'hfffe);
        mon_tx_wr_i = 2'h1;
        cyc(1);
        mon_tx_wr_i = 2'h0;
        chk({mon_tx_valid_o, monitor_tx_reg_o[7:0]}, 10'h13c);
        for (int i = 0; i < 20 && mon_tx_valid_o[0] !== 1'b0; i++) cyc(1);
        chk({mon_tx_valid_o, irq_status_reg_o[0]}, 3'h1);
        ci_byte_i = 8'h90;
        ci_valid_i = 2'h2;
        cyc(1);
        ci_valid_i = 2'h0;
        chk({irq_status_reg_o[11], ci_receive_reg_o[7:4]}, 5'h19);
        monitor_ci_reset_cmd_i = 2'h1;
        cyc(1);
        monitor_ci_reset_cmd_i = 2'h0;
        chk(irq_status_reg_o, 16'h0800);
        cwr(2'h2, 16'hf7ff);
        chk(irq_status_reg_o, 16'h0000);
        // Lock after a ready byte holds until the register is read
        mon_byte_i = 16'h005a;
        mon_frame_i = 2'h1;
        cyc(2);
        mon_frame_i = 2'h0;
        cwr(2'h1, 16'hfffb);
        mon_byte_i = 16'h0066;
        mon_frame_i = 2'h1;
        cyc(3);
        mon_frame_i = 2'h0;
        chk({irq_status_reg_o[7:0], monitor_rx_reg_o[7:0]}, 16'h005a);
        mon_rx_rd_i = 2'h1;
        cyc(1);
        mon_rx_rd_i = 2'h0;
        mon_frame_i = 2'h1;
        cyc(2);
        mon_frame_i = 2'h0;
        chk({irq_status_reg_o[2], monitor_rx_reg_o[7:0]}, 9'h166);
        mon_rx_rd_i = 2'h1;
        cyc(1);
        mon_rx_rd_i = 2'h0;
        // Two differing bytes raise the receive abort
        mon_byte_i = 16'h0011;
        mon_frame_i = 2'h1;
        cyc(1);
        mon_byte_i = 16'h0022;
        cyc(1);
        mon_frame_i = 2'h0;
        chk(irq_status_reg_o[7:0], 8'h14);
        monitor_ci_reset_cmd_i = 2'h1;
        cyc(1);
        monitor_ci_reset_cmd_i = 2'h0;
        mon_eom_i = 2'h1;
        cyc(1);
        mon_eom_i = 2'h0;
        mon_frame_i = 2'h1;
        cyc(2);
        mon_frame_i = 2'h0;
        ci_byte_i = 8'h07;
        ci_valid_i = 2'h1;
        cyc(1);
        ci_valid_i = 2'h0;
        chk({irq_status_reg_o[7:0], ci_receive_reg_o[3:0]}, 12'h287);
        monitor_ci_reset_cmd_i = 2'h2;
        cyc(1);
        monitor_ci_reset_cmd_i = 2'h0;
        chk(irq_status_reg_o, 16'h0028);
        wrap_up();
    end
endmodule // test_hdlc_mci_soft_reset_flags
